// >>> core/sarcc_ctrl.sv
// Conversion, calibration, end-of-conversion and output control of the converter.
// Operation
// - With select and read held low, done flag stays low exactly four clocks.
// - Otherwise done flag returns high within four clocks of read or conversion.
// - Input above positive reference yields an all-ones code.
// - Input below ground or negative reference yields an all-zeros code.
// - Each search starts with only the most significant bit set.
// - Clear trial bit when input below trial level, then set next lower bit.
// - Search tries every bit once; final trial word becomes the result.
// - Idle, all elements but the top one in bipolar mode track the input with the sampling switch closed.
// - Conversion opens the sampling switch first and ignores the live input.
// - Bipolar mode ties the top element to reference; code is offset binary.
// - Comparator offset is stored on the array while tracking.
// - Calibration trims each bit to balance lower bits plus one dummy unit.
// - Three-state parallel output for 8/16-bit hosts plus a serial stream.
// - Falling hold starts conversion; device returns to track on its own.
// - Sequencer runs on master clock delayed and divided by four.
// - Conversion lasts 49, 57 or 65 clocks for 12, 14, 16 bits.
// - Reset clears everything; its release starts a full calibration.
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_ctrl import sarcc_pkg::*; #(
  parameter int RES_W = `SARCC_RES_W_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hold_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_hi_sel,
  input wire logic bipolar_sel,
  input wire logic comp_below,
  output logic sampling_switch,
  output logic elem_to_input,
  output logic msb_to_ref,
  output logic [RES_W-1:0] trial_word,
  output logic conv_busy,
  output logic cal_busy,
  output logic [`SARCC_TRIM_W-1:0] trim_code,
  output logic [RES_W*`SARCC_TRIM_W-1:0] trim_bus,
  output logic eoc_n,
  output logic [`SARCC_BUS_W-1:0] data_out,
  output logic data_oe,
  output logic serial_data,
  output logic serial_clk
);
  localparam int TW = `SARCC_TRIM_W;
  localparam int IW = $clog2(RES_W);
  localparam int CW = $clog2(RES_W + 1);
  localparam logic [RES_W-1:0] MSB_WORD = {1'h1, {(RES_W-1){1'h0}}};
  localparam logic [TW-1:0] TMSB = {1'h1, {(TW-1){1'h0}}};
  localparam logic [RES_W-1:0] LSB_WORD = {{(RES_W-1){1'h0}}, 1'h1};
  localparam int A_CONV = `SARCC_DIV * RES_W + 1;

  logic [`SARCC_PIN_N-1:0] pin_s1_r, pin_s2_r;
  logic hold_d_r, rst_d_r;
  sarcc_state_t state_r, state_nxt;
  logic [1:0] ph_r, low_cnt_r;
  logic [RES_W-1:0] trial_r, mask_r, result_r, ser_sh_r;
  logic [TW-1:0] tmask_r, tcode_r;
  logic [TW-1:0] trim_mem_r [RES_W];
  logic [IW-1:0] cal_bit_r;
  logic [CW-1:0] ser_cnt_r;
  logic sw_r, elem_in_r, msb_ref_r, conv_busy_r, cal_busy_r, eoc_n_r;
  logic [`SARCC_BUS_W-1:0] data_r;
  logic data_oe_r, sdat_r, sclk_r, sdiv_r;
  logic [RES_W-1:0] conv_step;
  logic [TW-1:0] trim_step;

  // Only the second synchroniser stage is read below.
  wire hold_s = pin_s2_r[`SARCC_PIN_HOLD];
  wire read_s = !pin_s2_r[`SARCC_PIN_CS] && !pin_s2_r[`SARCC_PIN_RD];
  wire byte_s = pin_s2_r[`SARCC_PIN_BYTE];
  wire bip_s = pin_s2_r[`SARCC_PIN_BIP];
  wire comp_s = pin_s2_r[`SARCC_PIN_COMP];
  wire hold_fall = hold_d_r && !hold_s;
  wire in_track = state_r == ST_TRACK;
  wire conv_start = hold_fall && in_track && !rst_d_r;
  // A start inside the minimum low time must still release the flag once that time is up.
  wire new_cycle = conv_start || conv_busy_r;
  wire cal_go = in_track && rst_d_r;
  wire tick = ph_r == `SARCC_PH_LAST;
  wire conv_tick = (state_r == ST_CONV) && tick;
  wire cal_tick = (state_r == ST_CAL) && tick;
  wire conv_done = conv_tick && mask_r[0];
  wire cal_last = cal_bit_r == IW'(RES_W - 1);
  wire [RES_W-1:0] cal_word = LSB_WORD << cal_bit_r;
  wire [`SARCC_BUS_W-1:0] res16 = `SARCC_BUS_W'(result_r);
  wire [`SARCC_BUS_W-1:0] hi_byte = {{`SARCC_BYTE_W{1'h0}},
                                     res16[`SARCC_BUS_W-1 -: `SARCC_BYTE_W]};

  // A comparator that never reports "below" leaves every bit set, one that always does
  // clears them all, so out-of-range inputs clip rather than wrap.
  sarcc_sar_step #(.W(RES_W)) u_conv_step (
    .word_in(trial_r),
    .mask(mask_r),
    .keep(!comp_s),
    .word_out(conv_step)
  );

  // A trim bit stays set while the bit still weighs less than its lower bits plus the dummy.
  sarcc_sar_step #(.W(TW)) u_trim_step (
    .word_in(tcode_r),
    .mask(tmask_r),
    .keep(comp_s),
    .word_out(trim_step)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_TRACK: begin
        if (rst_d_r) begin
          state_nxt = ST_CAL;
        end else if (conv_start) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_nxt = ST_TRACK;
        end
      end
      ST_CAL: begin
        if (cal_tick && tmask_r[0] && cal_last) begin
          state_nxt = ST_TRACK;
        end
      end
      default: state_nxt = ST_TRACK;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1_r <= `SARCC_PIN_RST_VAL;
      pin_s2_r <= `SARCC_PIN_RST_VAL;
      hold_d_r <= 1'h1;
      rst_d_r <= 1'h1;
    end else if (clk_en) begin
      pin_s1_r <= {comp_below, bipolar_sel, byte_hi_sel, rd_n, cs_n, hold_n};
      pin_s2_r <= pin_s1_r;
      hold_d_r <= hold_s;
      rst_d_r <= 1'h0;
    end
  end

  // Switch closed in track keeps the comparator offset stored on the array.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_TRACK;
      sw_r <= 1'h1;
      elem_in_r <= 1'h1;
      msb_ref_r <= 1'h0;
      conv_busy_r <= 1'h0;
      cal_busy_r <= 1'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      sw_r <= state_nxt == ST_TRACK;
      elem_in_r <= state_nxt == ST_TRACK;
      msb_ref_r <= (state_nxt == ST_TRACK) && bip_s;
      conv_busy_r <= state_nxt == ST_CONV;
      cal_busy_r <= state_nxt == ST_CAL;
    end
  end

  // Trials run on the divided clock; the phase restarts at each sequence start.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ph_r <= `SARCC_PH_ZERO;
      trial_r <= '0;
      mask_r <= '0;
      result_r <= '0;
      tmask_r <= '0;
      tcode_r <= '0;
      cal_bit_r <= '0;
      for (int i = 0; i < RES_W; i++) begin
        trim_mem_r[i] <= '0;
      end
    end else if (clk_en) begin
      ph_r <= (conv_start || cal_go) ? `SARCC_PH_ZERO : ph_r + `SARCC_PH_ONE;
      if (conv_start) begin
        trial_r <= MSB_WORD;
        mask_r <= MSB_WORD;
      end else if (cal_go) begin
        trial_r <= LSB_WORD;
        tmask_r <= TMSB;
        tcode_r <= TMSB;
        cal_bit_r <= '0;
      end else if (conv_tick) begin
        trial_r <= conv_step;
        mask_r <= mask_r >> 1;
        if (mask_r[0]) begin
          result_r <= conv_step;
        end
      end else if (cal_tick) begin
        tcode_r <= tmask_r[0] ? TMSB : trim_step;
        tmask_r <= tmask_r[0] ? TMSB : (tmask_r >> 1);
        if (tmask_r[0]) begin
          trim_mem_r[cal_bit_r] <= trim_step;
          cal_bit_r <= cal_bit_r + IW'(1);
          trial_r <= cal_word << 1;
        end else begin
          trial_r <= cal_word;
        end
      end
    end
  end

  // The done flag stays low at least four clocks and is released by a read or a new start.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      eoc_n_r <= 1'h1;
      low_cnt_r <= `SARCC_PH_ZERO;
    end else if (clk_en) begin
      if (conv_done) begin
        eoc_n_r <= 1'h0;
        low_cnt_r <= `SARCC_PH_ZERO;
      end else if (!eoc_n_r) begin
        if ((read_s || new_cycle) && low_cnt_r == `SARCC_EOC_LAST) begin
          eoc_n_r <= 1'h1;
        end
        if (low_cnt_r != `SARCC_EOC_LAST) begin
          low_cnt_r <= low_cnt_r + `SARCC_PH_ONE;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_r <= '0;
      data_oe_r <= 1'h0;
    end else if (clk_en) begin
      data_oe_r <= read_s;
      data_r <= byte_s ? hi_byte : res16;
    end
  end

  // Serial stream, most significant bit first, clock levels two master clocks long.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ser_sh_r <= '0;
      ser_cnt_r <= '0;
      sdat_r <= 1'h0;
      sclk_r <= 1'h0;
      sdiv_r <= 1'h0;
    end else if (clk_en) begin
      if (conv_done) begin
        ser_sh_r <= conv_step;
        ser_cnt_r <= CW'(RES_W);
        sdat_r <= conv_step[RES_W-1];
        sclk_r <= 1'h0;
        sdiv_r <= 1'h0;
      end else if (ser_cnt_r != '0) begin
        sdiv_r <= !sdiv_r;
        if (sdiv_r) begin
          sclk_r <= !sclk_r;
          if (sclk_r) begin
            ser_sh_r <= ser_sh_r << 1;
            sdat_r <= ser_sh_r[RES_W-2];
            ser_cnt_r <= ser_cnt_r - CW'(1);
          end
        end
      end
    end
  end

  assign sampling_switch = sw_r;
  assign elem_to_input = elem_in_r;
  assign msb_to_ref = msb_ref_r;
  assign trial_word = trial_r;
  assign conv_busy = conv_busy_r;
  assign cal_busy = cal_busy_r;
  assign trim_code = tcode_r;
  assign eoc_n = eoc_n_r;
  assign data_out = data_r;
  assign data_oe = data_oe_r;
  assign serial_data = sdat_r;
  assign serial_clk = sclk_r;
  for (genvar g = 0; g < RES_W; g++) begin : g_trim
    assign trim_bus[g*TW +: TW] = trim_mem_r[g];
  end

  default clocking cb @(posedge clock iff clk_en);
  endclocking
  default disable iff (sys_rst);

  sequence s_frozen;
    (!sw_r && conv_busy_r)[*8];
  endsequence
  sequence s_read_held;
    read_s[*4];
  endsequence

  a_start_msb_word: assert property (conv_start |=> (trial_r == MSB_WORD && mask_r == MSB_WORD))
    else $error("search did not start at half scale");
  a_trial_bit_clear: assert property (conv_tick && comp_s && !mask_r[0] |=>
    ((trial_r & $past(mask_r)) == '0 && (trial_r & ($past(mask_r) >> 1)) != '0))
    else $error("trial bit not cleared or next bit not set");
  a_trial_bit_keep: assert property (conv_tick && !comp_s |=> (trial_r & $past(mask_r)) != '0)
    else $error("trial bit lost although input was not below");
  a_conv_length: assert property (conv_start |-> ##[A_CONV:A_CONV] $fell(eoc_n_r))
    else $error("conversion length wrong");
  a_result_final: assert property (conv_done |=> result_r == trial_r)
    else $error("result is not the final trial word");
  a_sample_frozen: assert property (conv_start |=> s_frozen)
    else $error("sampling switch closed during conversion");
  a_track_idle: assert property (in_track |-> (sw_r && elem_in_r && !conv_busy_r && !cal_busy_r))
    else $error("idle but not tracking");
  a_bipolar_msb: assert property (msb_ref_r |-> (sw_r && $past(bip_s)))
    else $error("top element on reference outside track");
  a_eoc_width_min: assert property ($fell(eoc_n_r) |-> (!eoc_n_r)[*4])
    else $error("done flag low for under four clocks");
  a_eoc_read_held: assert property ($fell(eoc_n_r) ##0 s_read_held |=> eoc_n_r)
    else $error("done flag not released after four clocks of read");
  a_eoc_release: assert property (!eoc_n_r && $rose(read_s) |-> ##[1:4] eoc_n_r)
    else $error("done flag not released after read");
  a_eoc_conv_release: assert property (!eoc_n_r && conv_start |-> ##[1:4] eoc_n_r)
    else $error("done flag not released after new conversion");
  a_cal_lockout: assert property ((state_r == ST_CAL) |=> (state_r != ST_CONV))
    else $error("conversion started during calibration");
  a_reset_cal_start: assert property ($fell(sys_rst) |=> (state_r == ST_CAL && cal_busy_r))
    else $error("calibration did not start after reset");
endmodule

// >>> core/sarcc_consts.svh
// Constants for the converter conversion and calibration controller.
`ifndef SARCC_CONSTS_SVH
`define SARCC_CONSTS_SVH
`define SARCC_RES_W_DEF 16
`define SARCC_TRIM_W 4
`define SARCC_DIV 4
`define SARCC_PH_LAST 2'h3
`define SARCC_PH_ZERO 2'h0
`define SARCC_PH_ONE 2'h1
`define SARCC_EOC_LAST 2'h3
`define SARCC_BUS_W 16
`define SARCC_BYTE_W 8
`define SARCC_PIN_N 6
`define SARCC_PIN_HOLD 0
`define SARCC_PIN_CS 1
`define SARCC_PIN_RD 2
`define SARCC_PIN_BYTE 3
`define SARCC_PIN_BIP 4
`define SARCC_PIN_COMP 5
`define SARCC_PIN_RST_VAL 6'h07
`endif

// >>> core/sarcc_pkg.sv
// Types for the converter conversion and calibration controller.
package sarcc_pkg;
  typedef enum logic [1:0] {ST_TRACK, ST_CONV, ST_CAL} sarcc_state_t;
endpackage

// >>> core/sarcc_sar_step.sv
// One successive-approximation decision on a trial word.
`timescale 1ns/1ps
module sarcc_sar_step #(
  parameter int W = 16
) (
  input wire logic [W-1:0] word_in,
  input wire logic [W-1:0] mask,
  input wire logic keep,
  output logic [W-1:0] word_out
);
  // The bit under trial stays or clears, and the next lower bit is set for its trial.
  assign word_out = (keep ? word_in : (word_in & ~mask)) | (mask >> 1);
endmodule

// >>> bench/sarcc_analog_model.sv
// Comparator and held-charge model of the converter's analog array.
`timescale 1ns/1ps
module sarcc_analog_model #(
  parameter int W = 12
) (
  input wire logic clock,
  input wire logic sampling_switch,
  input wire logic msb_to_ref,
  input wire logic cal_busy,
  input wire logic cal_keep,
  input wire logic [W-1:0] trial_word,
  input wire integer analog_input,
  output logic comp_below
);
  int held = 0;
  // The charge follows the input only while the switch is closed; with the top element on
  // the reference the range doubles and is offset by half scale.
  always @(posedge clock) begin
    if (sampling_switch) begin
      held <= msb_to_ref ? (analog_input + (1 << W)) / 2 : analog_input;
    end
  end
  // Out-of-range charge settles the search at either end; calibration gets a fixed answer.
  assign comp_below = cal_busy ? cal_keep : (held < int'(trial_word));
endmodule

// >>> bench/sarcc_ctrl_test.sv
// Self-checking bench for the conversion and calibration controller.
`timescale 1ns/1ps
module sarcc_ctrl_test;
  import sarcc_pkg::*;
  localparam int W = 12;
  logic clock = 0, sys_rst = 1, clk_en = 1, hold_n = 1, cs_n = 1, rd_n = 1;
  logic byte_hi_sel = 0, bipolar_sel = 0, comp_below, cal_keep = 0;
  logic sampling_switch, elem_to_input, msb_to_ref, conv_busy, cal_busy, eoc_n;
  logic data_oe, serial_data, serial_clk;
  logic [W-1:0] trial_word, e;
  logic [3:0] trim_code;
  logic [W*4-1:0] trim_bus;
  logic [15:0] data_out;
  logic [W-1:0] exp_q[$];
  int analog_input = 0, err_count = 0, n_checks = 0, cyc = 0, k;
  int vals[7] = '{-7, 0, 4095, 9000, 2048, 2047, 1};

  always #2.5 clock = ~clock;

  sarcc_ctrl #(.RES_W(W)) sarcc_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .hold_n(hold_n), .cs_n(cs_n), .rd_n(rd_n), .byte_hi_sel(byte_hi_sel),
    .bipolar_sel(bipolar_sel), .comp_below(comp_below), .sampling_switch(sampling_switch),
    .elem_to_input(elem_to_input), .msb_to_ref(msb_to_ref), .trial_word(trial_word),
    .conv_busy(conv_busy), .cal_busy(cal_busy), .trim_code(trim_code), .trim_bus(trim_bus),
    .eoc_n(eoc_n), .data_out(data_out), .data_oe(data_oe), .serial_data(serial_data),
    .serial_clk(serial_clk));

  sarcc_analog_model #(.W(W)) sarcc_analog_model_inst (.clock(clock),
    .sampling_switch(sampling_switch), .msb_to_ref(msb_to_ref), .cal_busy(cal_busy),
    .cal_keep(cal_keep), .trial_word(trial_word), .analog_input(analog_input), .comp_below(comp_below));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [W-1:0] clip(input int v);
    if (v < 0) return '0;
    if (v > (1 << W) - 1) return '1;
    return v[W-1:0];
  endfunction

  task automatic wait_cal;
    k = 0;
    while (cal_busy !== 1'b0 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    repeat (5) @(negedge clock);
  endtask

  // Mode 0 reads after the result, 1 holds the read through the conversion, 2 never reads.
  task automatic convert(input int v, input int mode);
    int n;
    bit was_low;
    logic [W-1:0] x;
    x = clip(bipolar_sel ? (v + (1 << W)) / 2 : v);
    was_low = (eoc_n === 1'b0);
    analog_input = v;
    exp_q.push_back(x);
    cs_n = (mode != 1);
    rd_n = (mode != 1);
    hold_n = 0;
    n = 0;
    while (eoc_n !== 1'b0 || n < 10) begin
      @(negedge clock);
      n++;
      if (n == 4) hold_n = 1;
      if (n == 6) check(16'(trial_word), 16'(1 << (W - 1)), "first trial");
      if (n == 8 && was_low) check(16'(eoc_n), 16'h0001, "done flag on start");
      if (n == 10) check(16'({sampling_switch, elem_to_input, conv_busy}), 16'h0001, "hold");
      if (n == 10) analog_input = 4000 - v;
      if (n == 20) hold_n = 0;
      if (n == 24) hold_n = 1;
      if (n > 200) break;
    end
    check(16'(n >= 49 && n <= 56), 16'h0001, "conversion length");
    if (mode == 1) begin
      k = 0;
      while (eoc_n === 1'b0 && k < 20) begin
        k++;
        @(negedge clock);
      end
      check(16'(k), 16'h0004, "done low width");
    end
    if (mode == 2) return;
    cs_n = 0;
    rd_n = 0;
    k = 0;
    while (eoc_n !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    if (mode == 0) check(16'(k <= 7), 16'h0001, "done release on read");
    repeat (4) @(negedge clock);
    check(16'(data_oe), 16'h0001, "bus driven");
    check(data_out, 16'(x), "parallel word");
    byte_hi_sel = 1;
    repeat (5) @(negedge clock);
    check(data_out, 16'(x) >> 8, "high byte");
    byte_hi_sel = 0;
    cs_n = 1;
    rd_n = 1;
    repeat (7) @(negedge clock);
    check(16'(data_oe), 16'h0000, "bus released");
  endtask

  // Each finished conversion is compared against the oldest expected code.
  initial forever begin
    @(negedge eoc_n);
    @(negedge clock);
    e = exp_q.size() ? exp_q.pop_front() : ~trial_word;
    check(16'(trial_word), 16'(e), "result word");
    for (int i = W - 1; i >= 0; i--) begin
      @(posedge serial_clk);
      @(negedge clock);
      check(16'(serial_data), 16'(e[i]), "serial bit");
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h35d6));
    repeat (20) @(negedge clock);
    sys_rst = 0;
    repeat (2) @(negedge clock);
    check(16'(cal_busy), 16'h0001, "calibration after reset");
    check(16'(trim_code), 16'h0008, "trim search start");
    hold_n = 0;
    repeat (4) @(negedge clock);
    hold_n = 1;
    repeat (6) @(negedge clock);
    check(16'(conv_busy), 16'h0000, "hold during calibration");
    wait_cal();
    check(16'({sampling_switch, elem_to_input, msb_to_ref}), 16'h0006, "tracking");
    check(16'(trim_bus == '0), 16'h0001, "trims cleared");
    // A hold pulse while the clock enable is low must be missed entirely.
    clk_en = 0;
    hold_n = 0;
    repeat (6) @(negedge clock);
    hold_n = 1;
    repeat (2) @(negedge clock);
    clk_en = 1;
    repeat (6) @(negedge clock);
    check(16'(conv_busy), 16'h0000, "frozen while disabled");
    foreach (vals[i]) convert(vals[i], i % 3);
    bipolar_sel = 1;
    repeat (5) @(negedge clock);
    check(16'(msb_to_ref), 16'h0001, "bipolar top element");
    convert(-30, 0);
    convert(3000, 1);
    bipolar_sel = 0;
    repeat (5) @(negedge clock);
    repeat (6) convert(int'($urandom_range(4400)) - 150, 0);
    repeat (30) @(negedge clock);
    hold_n = 0;
    repeat (20) @(negedge clock);
    hold_n = 1;
    sys_rst = 1;
    repeat (2) @(negedge clock);
    check(16'({eoc_n, conv_busy, cal_busy}), 16'h0004, "reset aborts");
    cal_keep = 1;
    sys_rst = 0;
    repeat (2) @(negedge clock);
    check(16'(cal_busy), 16'h0001, "calibration again");
    wait_cal();
    check(16'(trim_bus == '1), 16'h0001, "trims kept");
    convert(1234, 1);
    repeat (60) @(negedge clock);
    check(16'(exp_q.size()), 16'h0000, "all results seen");
    tally_and_finish();
  end
endmodule
